/* rtl/aio_port_regs.svh */
// timing counts and codes for the analog i/o port bus interface
`ifndef AIO_PORT_REGS_SVH
`define AIO_PORT_REGS_SVH
`define MID_CODE      8'h80
`define CODE_STEPS    256
`define ACQ_CLKS      3'h4
`define NUM_BITS      4'h8
`define CLEAR_CODE    8'h00
`endif

/* rtl/aio_port_pkg.sv */
// types for the analog i/o port bus interface
package aio_port_pkg;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_ACQ    = 4'b0010,
		ST_BITS   = 4'b0100,
		ST_FINISH = 4'b1000
	} conv_state_t;
	typedef struct packed {
		logic sel;
		logic dac_dir;
		logic chan;
		logic wr;
		logic rd;
	} bus_ctl_t;
endpackage

/* rtl/dual_channel_adc_dac_bus_port.sv */
// bus interface and conversion sequencer of a two-channel 8-bit analog i/o port
// How it works
// - selected write with direction 0 picks channel by channel line and starts conversion
// - done flag goes high on falling write edge of a conversion-start access
// - done flag goes low at conversion end, held until next read or start
// - selected falling read edge returns done flag high regardless of address lines
// - selected with read low drives held result; read high releases the bus
// - direction 1, read high: write loads bus byte into output register a or b
// - direction 1, read low: write copies last result into chosen output register
// - conversion-start access with read high leaves data lines undriven
// - conversion-start access with read low drives previous result
// - result is offset binary, bias input gives midpoint code 80 hex
// - output register code 80 hex gives bias output, 00 and ff the ends
// - one code step is full scale over 256 for both converters
// - accesses are ignored and bus undriven while select is high
// - conversion begins on rising write edge of a conversion-start access
// - data line 7 carries the most significant bit
// - at conversion end approximation register goes to latch, then clears
`timescale 1ns/100ps
`include "aio_port_regs.svh"
module dual_channel_adc_dac_bus_port
	import aio_port_pkg::*;
(
	input  wire logic       SYS_CLK_I,      // 10 mhz system clock
	input  wire logic       RST_I,          // synchronous reset, active high
	input  wire logic       SEL_N_I,        // part select, active low
	input  wire logic       DAC_DIR_I,      // 0 converter start, 1 output register write
	input  wire logic       CHANNEL_PICK_I, // 0 channel a, 1 channel b
	input  wire logic       WR_N_I,         // write strobe, active low
	input  wire logic       RD_N_I,         // read strobe, active low
	input  wire logic       CONV_CLK_I,     // converter clock pin
	input  wire logic [7:0] PARALLEL_DATA_BUS_I,  // data bus input side, bit 7 msb
	output logic      [7:0] PARALLEL_DATA_BUS_O,  // data bus output side
	output logic            PARALLEL_DATA_BUS_OE_O, // high while driving the bus
	output logic            DONE_N_O,       // conversion done, active low
	output logic            CHANNEL_O,      // channel held for the running conversion
	output logic            SAMPLE_O,       // analog input being tracked
	output logic            COMPARE_O,      // comparator request for current trial
	output logic      [7:0] TRIAL_O,        // trial code for the comparator dac
	input  wire logic       CMP_I,          // comparator: input above trial code
	output logic      [7:0] OUTPUT_REGISTER_A_O, // dac a code, offset binary
	output logic      [7:0] OUTPUT_REGISTER_B_O  // dac b code, offset binary
);

	// two-stage synchronisers for all pin inputs except the clock and the reset
	// strobes, address and data come from the host's clock, so nothing reads them raw
	// no reset here: the idle pin levels flush through within two cycles of reset
	bus_ctl_t   ctl_s1, ctl;
	logic [7:0] data_s1, data_s;
	logic       cclk_s1, cclk, cclk_d, cmp_s1, cmp;
	bus_ctl_t   ctl_d;
	always_ff @(posedge SYS_CLK_I) begin
		ctl_s1  <= '{sel: ~SEL_N_I, dac_dir: DAC_DIR_I, chan: CHANNEL_PICK_I, wr: ~WR_N_I, rd: ~RD_N_I};
		ctl     <= ctl_s1;
		data_s1 <= PARALLEL_DATA_BUS_I;
		data_s  <= data_s1;
		cclk_s1 <= CONV_CLK_I;
		cclk    <= cclk_s1;
		cmp_s1  <= CMP_I;
		cmp     <= cmp_s1;
	end

	// delayed copies for edge detection
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			ctl_d  <= '0;
			cclk_d <= 1'b0;
		end else begin
			ctl_d  <= ctl;
			cclk_d <= cclk;
		end
	end

	logic wr_fall, wr_rise, rd_fall, start_fall, start_rise, dac_wr, cclk_fall;
	always_comb begin
		wr_fall    = ctl.sel & ctl.wr & ~ctl_d.wr;
		wr_rise    = ctl.sel & ~ctl.wr & ctl_d.wr;
		rd_fall    = ctl.sel & ctl.rd & ~ctl_d.rd;
		start_fall = wr_fall & ~ctl.dac_dir;
		start_rise = wr_rise & ~ctl.dac_dir;
		dac_wr     = wr_rise & ctl.dac_dir;
		cclk_fall  = ~cclk & cclk_d;
	end

	// conversion sequencer
	conv_state_t state, next_state;
	logic [2:0]  acq_cnt;
	logic [3:0]  bit_cnt;
	logic [7:0]  approximation_register, result_latch;
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE:   if (start_rise) next_state = ST_ACQ;
			ST_ACQ:    if (cclk_fall && acq_cnt == `ACQ_CLKS - 3'h1) next_state = ST_BITS;
			ST_BITS:   if (cclk_fall && bit_cnt == `NUM_BITS - 4'h1) next_state = ST_FINISH;
			ST_FINISH: next_state = ST_IDLE;
			default:   next_state = ST_IDLE;
		endcase
		if (start_rise) next_state = ST_ACQ; // a new start restarts the sequence
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) state <= ST_IDLE;
		else       state <= next_state;
	end

	// acquisition count, then one decision per converter clock msb first
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			acq_cnt                <= 3'h0;
			bit_cnt                <= 4'h0;
			approximation_register <= `CLEAR_CODE;
			result_latch           <= `MID_CODE;
			CHANNEL_O              <= 1'b0;
		end else if (start_rise) begin
			acq_cnt                <= 3'h0;
			bit_cnt                <= 4'h0;
			approximation_register <= `CLEAR_CODE;
			CHANNEL_O              <= ctl.chan;
			// a start on the finishing cycle must not lose the finished result
			if (state == ST_FINISH) result_latch <= approximation_register;
		end else if (state == ST_ACQ && cclk_fall) begin
			acq_cnt <= acq_cnt + 3'h1;
		end else if (state == ST_BITS && cclk_fall) begin
			approximation_register[3'h7 - bit_cnt[2:0]] <= cmp;
			bit_cnt <= bit_cnt + 4'h1;
		end else if (state == ST_FINISH) begin
			result_latch           <= approximation_register;
			approximation_register <= `CLEAR_CODE;
		end
	end

	// trial code: bits decided so far, current bit set
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			TRIAL_O   <= `MID_CODE;
			SAMPLE_O  <= 1'b0;
			COMPARE_O <= 1'b0;
		end else begin
			TRIAL_O   <= approximation_register | (`MID_CODE >> bit_cnt[2:0]);
			SAMPLE_O  <= (next_state == ST_ACQ);
			COMPARE_O <= (next_state == ST_BITS);
		end
	end

	// done flag: clear to high on read or start falling edge, low at end; set wins
	// a read racing the conversion end would otherwise hide the fresh result
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I)                     DONE_N_O <= 1'b1;
		else if (state == ST_FINISH)   DONE_N_O <= 1'b0;
		else if (start_fall || rd_fall) DONE_N_O <= 1'b1;
	end

	// output registers; done flag untouched here
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			OUTPUT_REGISTER_A_O <= `MID_CODE;
			OUTPUT_REGISTER_B_O <= `MID_CODE;
		end else if (dac_wr) begin
			if (!ctl.chan) OUTPUT_REGISTER_A_O <= ctl.rd ? result_latch : data_s;
			else           OUTPUT_REGISTER_B_O <= ctl.rd ? result_latch : data_s;
		end
	end

	// data bus drive: only selected with read low, in any mode
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			PARALLEL_DATA_BUS_O    <= 8'h00;
			PARALLEL_DATA_BUS_OE_O <= 1'b0;
		end else begin
			PARALLEL_DATA_BUS_O    <= result_latch;
			PARALLEL_DATA_BUS_OE_O <= ctl.sel & ctl.rd;
		end
	end

	// bus drive checks
	bus_off_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		!(ctl.sel && ctl.rd) |=> !PARALLEL_DATA_BUS_OE_O)
		else $error("bus driven without select and read");
	bus_on_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(ctl.sel && ctl.rd) |=> PARALLEL_DATA_BUS_OE_O && PARALLEL_DATA_BUS_O == $past(result_latch))
		else $error("read does not drive result");

	// done flag checks
	done_set_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(rd_fall && state != ST_FINISH) |=> DONE_N_O)
		else $error("read did not clear done");
	start_done_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(start_fall && state != ST_FINISH) |=> DONE_N_O)
		else $error("start did not clear done");
	done_low_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		state == ST_FINISH |=> !DONE_N_O && result_latch == $past(approximation_register))
		else $error("end of conversion not flagged");

	// sequencer checks
	sar_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		state == ST_FINISH && !start_rise |=> approximation_register == 8'h00)
		else $error("register not cleared");
	conv_begin_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		start_rise |=> state == ST_ACQ && CHANNEL_O == $past(ctl.chan))
		else $error("conversion did not begin");
	no_early_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		state == ST_BITS |=> $stable(result_latch))
		else $error("result exposed early");
	eight_bits_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		state == ST_FINISH |-> bit_cnt == `NUM_BITS)
		else $error("conversion ended early");
	sample_on_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		state == ST_ACQ |-> SAMPLE_O)
		else $error("input not tracked");
	trial_first_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		start_rise |=> ##1 TRIAL_O == `MID_CODE)
		else $error("first trial not midpoint");
	chan_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		!start_rise |=> $stable(CHANNEL_O))
		else $error("channel moved mid conversion");

	// output register checks
	dac_load_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		dac_wr && !ctl.chan && !ctl.rd |=> OUTPUT_REGISTER_A_O == $past(data_s))
		else $error("dac a not loaded");
	dac_copy_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		dac_wr && ctl.chan && ctl.rd |=> OUTPUT_REGISTER_B_O == $past(result_latch) && $stable(DONE_N_O))
		else $error("dac b copy failed");
	dac_a_copy_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		dac_wr && !ctl.chan && ctl.rd |=> OUTPUT_REGISTER_A_O == $past(result_latch))
		else $error("dac a copy failed");
	dac_keep_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		!dac_wr |=> $stable(OUTPUT_REGISTER_A_O) && $stable(OUTPUT_REGISTER_B_O))
		else $error("output register moved without write");

endmodule

/* testbench/aio_host_model.sv */
// host bus master model driving the analog i/o port pins
`timescale 1ns/100ps
module aio_host_model (
	input  wire logic       clk_i,   // system clock
	output logic            sel_n_o, // part select, active low
	output logic            dir_o,   // 0 converter start, 1 output register write
	output logic            chan_o,  // channel line
	output logic            wr_n_o,  // write strobe, active low
	output logic            rd_n_o,  // read strobe, active low
	output logic      [7:0] data_o   // write byte, bit 7 msb
);
	// idle bus: deselected, strobes high
	initial begin
		sel_n_o = 1'b1;
		dir_o = 1'b0;
		chan_o = 1'b0;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		data_o = 8'h00;
	end
	// let n edges pass, then move just after the edge
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// address, read level and data set up before any strobe
	task automatic setup(input logic s, input logic d, input logic c, input logic r, input logic [7:0] v);
		sel_n_o = s;
		dir_o = d;
		chan_o = c;
		rd_n_o = r;
		data_o = v;
		hold(6);
	endtask
	// write strobe moves while the read level stays put
	task automatic set_wr_n(input logic v);
		wr_n_o = v;
		hold(6);
	endtask
	// end of access: deselect, release read, scramble the stale byte
	task automatic quit();
		rd_n_o = 1'b1;
		sel_n_o = 1'b1;
		data_o = ~data_o;
		hold(6);
	endtask
endmodule

/* testbench/dual_channel_adc_dac_bus_port_test.sv */
// self-checking bench for the analog i/o port bus interface
`timescale 1ns/100ps
module dual_channel_adc_dac_bus_port_test;
	logic       clk = 1'b0, rst = 1'b1, conv = 1'b0, sel_n, dir, ch, wr_n, rd_n, oe, done_n, chan;
	logic       sample, compare;
	logic [7:0] din, dout, trial, reg_a, reg_b, ain = 8'h00;
	int         n_fail = 0, checks_done = 0, cyc = 0;
	always #50 clk = ~clk;
	// converter clock, eight system clocks a period
	always begin
		repeat (4) @(posedge clk);
		#1 conv = ~conv;
	end
	// comparator: analog input against trial code
	wire cmp = (ain >= trial);
	dual_channel_adc_dac_bus_port u_dual_channel_adc_dac_bus_port (.SYS_CLK_I(clk), .RST_I(rst),
		.SEL_N_I(sel_n), .DAC_DIR_I(dir), .CHANNEL_PICK_I(ch), .WR_N_I(wr_n), .RD_N_I(rd_n),
		.CONV_CLK_I(conv), .PARALLEL_DATA_BUS_I(din), .PARALLEL_DATA_BUS_O(dout),
		.PARALLEL_DATA_BUS_OE_O(oe), .DONE_N_O(done_n), .CHANNEL_O(chan), .SAMPLE_O(sample),
		.COMPARE_O(compare), .TRIAL_O(trial), .CMP_I(cmp), .OUTPUT_REGISTER_A_O(reg_a),
		.OUTPUT_REGISTER_B_O(reg_b));
	aio_host_model u_host (.clk_i(clk), .sel_n_o(sel_n), .dir_o(dir), .chan_o(ch), .wr_n_o(wr_n),
		.rd_n_o(rd_n), .data_o(din));
	// compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// counts, verdict, end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// cycle ceiling against a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			wrap_up();
		end
	end
	// conversion start with read level r, wait for done, look at the bus
	task automatic t_conv(input logic c, input logic [7:0] v, input logic r, input logic [7:0] prev);
		int   k;
		logic saw;
		ain = v;
		k = 0;
		saw = 1'b0;
		u_host.setup(1'b0, 1'b0, c, r, 8'h00);
		u_host.set_wr_n(1'b0);
		check(done_n, 1'b1, "done set at start");
		check(oe, !r, "bus drive at start");
		if (!r) check(dout, prev, "previous result");
		u_host.set_wr_n(1'b1);
		check(chan, c, "channel taken");
		check({6'h00, sample, compare}, 8'h02, "tracking after start");
		check(trial, 8'h80, "first trial at midpoint");
		while (done_n !== 1'b0 && k < 400) begin
			u_host.hold(1);
			saw = saw | (compare === 1'b1);
			k++;
		end
		check({7'h00, k > 80 && k < 400}, 8'h01, "conversion length");
		check({7'h00, saw}, 8'h01, "bit decisions seen");
		u_host.hold(10);
		check(done_n, 1'b0, "done held low");
		check({6'h00, sample, compare}, 8'h00, "sequencer idle");
		if (!r) check(dout, v, "new result on bus");
		u_host.quit();
		$display("test conversion done");
	endtask
	// read with odd address lines
	task automatic t_read(input logic [7:0] v);
		u_host.setup(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
		check(oe, 1'b1, "read drives bus");
		check(dout, v, "read result");
		check(done_n, 1'b1, "read clears done");
		u_host.quit();
		check(oe, 1'b0, "bus released");
		$display("test read done");
	endtask
	// output register write, byte or copy of the last result
	task automatic t_dac(input logic c, input logic r, input logic [7:0] d, input logic [7:0] ea, input logic [7:0] eb);
		logic dn;
		u_host.setup(1'b0, 1'b1, c, r, d);
		dn = done_n;
		u_host.set_wr_n(1'b0);
		u_host.set_wr_n(1'b1);
		check(reg_a, ea, "register a");
		check(reg_b, eb, "register b");
		check(done_n, dn, "done unchanged");
		u_host.quit();
		$display("test register write done");
	endtask
	// main sequence; the third conversion starts with done low, the first two writes keep it low
	initial begin
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		u_host.hold(3);
		check(reg_a, 8'h80, "reset code");
		t_conv(1'b0, 8'h80, 1'b1, 8'h00);
		t_read(8'h80);
		t_conv(1'b1, 8'ha5, 1'b0, 8'h80);
		t_conv(1'b0, 8'h5a, 1'b1, 8'ha5);
		t_dac(1'b0, 1'b1, 8'h3c, 8'h3c, 8'h80);
		t_dac(1'b1, 1'b1, 8'hc3, 8'h3c, 8'hc3);
		t_dac(1'b1, 1'b0, 8'h00, 8'h3c, 8'h5a);
		t_read(8'h5a);
		u_host.setup(1'b1, 1'b1, 1'b0, 1'b0, 8'h11);
		u_host.set_wr_n(1'b0);
		u_host.set_wr_n(1'b1);
		check(oe, 1'b0, "deselected bus");
		check(reg_a, 8'h3c, "deselected write");
		u_host.quit();
		$display("test deselect done");
		wrap_up();
	end
endmodule
